// [logic/quadrature_position_decoder.sv]
// quadrature position decoder: phase inputs, position count, time stamps
// assumes phase inputs are already synchronous to CLOCK and bus master
// keeps strobes one cycle long
`timescale 1ns/1ns

// What this block does
// [R1] Decodes the two encoder phases into a 16-bit free-running position readable by software.
// [R2] A speed switch stops servicing one phase at high speed so faster signals still decode.
// [R3] Every counted edge also records a time stamp from the primary timebase; an initialize does not.
// [R4] The two-bit sequence field selects primary or secondary role and normal or fast mode.
// [R5] The two-bit service request means none at reset, unused, read timebase, or initialize.
// [R6] The two-bit priority field means disabled, low, medium or high priority.
// [R7] No interrupt is used or raised for position updates.
// [R8] The function select code is a build-time parameter, not a wired constant.
// [R9] Index pulses are not processed here; a separate capture function handles them.
// [R10] Count up when phase A leads, down when B leads, wrapping at the count width.
module quadrature_position_decoder #(
  parameter logic [3:0] FUNC_CODE = 4'h6,  // see [R8]
  parameter int         POS_W     = 16,
  parameter int         TB_W      = 16
) (
  // clock and reset
  input  wire  logic                   CLOCK,
  input  wire  logic                   ARST_N,
  // register port
  input  wire  quad_pkg::bus_req_t     BUS_REQ,
  output logic [quad_pkg::DATA_W-1:0]  BUS_RDATA,
  // encoder phases
  input  wire  logic                   PHASE_A,
  input  wire  logic                   PHASE_B,
  // status
  output logic [3:0]                   FUNC_SEL,
  output logic                         FAST_ACTIVE
);
  import quad_pkg::*;

  // widths other than 16 would break the wrap and the bus word
  if (POS_W != 16 || TB_W != 16) begin : g_width_check
    $error("position and timebase widths must be 16");
  end

  // ****************************************
  // state
  // ****************************************
  logic [15:0] ctrl_r;
  logic [7:0]  speed_r;
  logic [15:0] pos_r;
  logic [15:0] stamp_r;
  logic [15:0] tbread_r;
  logic [15:0] tb_r;
  logic [1:0]  phase_r;
  logic        fast_r;
  logic [15:0] rdata_r;

  seq_t        seq;
  pri_t        pri;
  logic        wr_ctrl;
  hsr_t        hsr_new;
  logic [1:0]  phase_now;
  logic        step_up;
  logic        step_dn;
  logic [15:0] pos_nxt;
  logic        edge_seen;

  // phases are kept as {B, A} so the step table reads with A leading
  assign seq       = seq_t'(ctrl_r[SEQ_LSB +: 2]);   // see [R4]
  assign pri       = pri_t'(ctrl_r[PRI_LSB +: 2]);   // see [R6]
  assign wr_ctrl   = BUS_REQ.wr && (BUS_REQ.addr == OFF_CTRL);
  assign hsr_new   = wr_ctrl ? hsr_t'(BUS_REQ.wdata[HSR_LSB +: 2]) : HSR_NONE;
  assign phase_now = {PHASE_B, PHASE_A};             // no index input, see [R9]

  // ****************************************
  // control and service requests
  // ****************************************
  // request bits are consumed at once, so the field reads back as none
  // priority and role fields are stored as written
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_r  <= CTRL_RST;                      // see [R5]
      speed_r <= SPEED_RST;
    end else if (wr_ctrl) begin
      ctrl_r  <= {BUS_REQ.wdata[15:4], HSR_NONE, BUS_REQ.wdata[1:0]};
      speed_r <= BUS_REQ.wdata[SPEED_LSB +: 8];
    end
  end

  // free-running primary timebase
  // wraps silently; software works with differences of two readings
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      tb_r <= 16'h0000;
    end else begin
      tb_r <= tb_r + 16'h0001;
    end
  end

  // read timebase on request
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      tbread_r <= 16'h0000;
    end else if (hsr_new == HSR_READTB) begin
      tbread_r <= tb_r;                         // see [R5]
    end
  end

  // ****************************************
  // quadrature decode
  // ****************************************
  // gray step table on {B, A}: 00->01->11->10 counts up, A leading
  // double jumps and repeats fall to default and are ignored
  always_comb begin
    step_up = 1'b0;
    step_dn = 1'b0;
    case ({phase_r, phase_now})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: step_up = 1'b1;  // see [R10]
      4'b0010, 4'b1011, 4'b1101, 4'b0100: step_dn = 1'b1;  // see [R10]
      default: ;
    endcase
  end

  // in fast mode only phase A edges are serviced; each counts two
  // limitation: the count may drift by one slot when the switch engages or drops
  always_comb begin
    pos_nxt   = pos_r;
    edge_seen = 1'b0;
    if (pri != PRI_OFF) begin                   // see [R6]
      if (fast_r) begin
        if (phase_r[0] != phase_now[0]) begin    // see [R2]
          edge_seen = 1'b1;
          pos_nxt   = (phase_now[1] != phase_now[0]) ? pos_r + 16'h0002 : pos_r - 16'h0002;
        end
      end else if (step_up) begin
        edge_seen = 1'b1;
        pos_nxt   = pos_r + 16'h0001;           // see [R1]
      end else if (step_dn) begin
        edge_seen = 1'b1;
        pos_nxt   = pos_r - 16'h0001;           // wraps, see [R10]
      end
    end
  end

  // position, phase history and stamp
  // an initialize request wins over an edge in the same cycle
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      pos_r   <= POS_RST;
      phase_r <= 2'b00;
      stamp_r <= 16'h0000;
    end else begin
      phase_r <= phase_now;
      if (hsr_new == HSR_INIT) begin
        pos_r <= POS_RST;
      end else begin
        pos_r <= pos_nxt;                       // see [R1]
        if (edge_seen) begin
          stamp_r <= tb_r;                      // see [R3]
        end
      end
    end
  end

  // ****************************************
  // speed switch
  // ****************************************
  // fast allowed only in fast sequence modes; leaves fast when edges slow down
  // gap saturates so a stopped shaft never wraps back under the engage limit
  // release limit is twice the engage limit, a hysteresis against chatter
  logic [7:0] gap_r;
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      gap_r      <= 8'h00;
      fast_r     <= 1'b0;
    end else begin
      if (edge_seen) begin
        gap_r <= 8'h00;
      end else if (gap_r != 8'hFF) begin
        gap_r <= gap_r + 8'h01;
      end
      if (!(seq == SEQ_PRI_FAST || seq == SEQ_SEC_FAST) || hsr_new == HSR_INIT) begin
        fast_r <= 1'b0;
      end else if (edge_seen && gap_r < speed_r) begin
        fast_r <= 1'b1;                         // see [R2]
      end else if ({1'b0, gap_r} > {speed_r, 1'b0}) begin
        fast_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // register reads, no interrupt state kept (see [R7])
  // read data stands for one cycle only and is zero otherwise
  // ****************************************
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_r <= 16'h0000;
    end else if (BUS_REQ.rd) begin
      if (BUS_REQ.addr == OFF_CTRL) begin
        rdata_r <= {speed_r, ctrl_r[7:0]};
      end else if (BUS_REQ.addr == OFF_POSITION) begin
        rdata_r <= pos_r;                       // see [R1]
      end else if (BUS_REQ.addr == OFF_STAMP) begin
        rdata_r <= stamp_r;                     // see [R3]
      end else if (BUS_REQ.addr == OFF_TBREAD) begin
        rdata_r <= tbread_r;
      end else if (BUS_REQ.addr == OFF_STATUS) begin
        rdata_r <= {11'h000, FUNC_CODE, fast_r};
      end else if (BUS_REQ.addr == OFF_TIMEBASE) begin
        rdata_r <= tb_r;
      end else begin
        rdata_r <= 16'h0000;
      end
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  // status outputs
  assign BUS_RDATA   = rdata_r;
  assign FUNC_SEL    = FUNC_CODE;               // see [R8]
  assign FAST_ACTIVE = fast_r;

endmodule

// [pkg/quad_pkg.sv]
// constants and carriers for the quadrature position decoder
// assumes a single 100 MHz clock domain and a plain strobe register port
package quad_pkg;

  // ****************************************
  // register bus
  // ****************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [3:0] OFF_CTRL     = 4'h0;
  localparam logic [3:0] OFF_POSITION = 4'h1;
  localparam logic [3:0] OFF_STAMP    = 4'h2;
  localparam logic [3:0] OFF_TBREAD   = 4'h3;
  localparam logic [3:0] OFF_STATUS   = 4'h4;
  localparam logic [3:0] OFF_TIMEBASE = 4'h5;

  // control word field positions
  localparam int SEQ_LSB = 0;
  localparam int HSR_LSB = 2;
  localparam int PRI_LSB = 4;
  localparam int SPEED_LSB = 8;

  // reset values
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [7:0]  SPEED_RST  = 8'h04;
  localparam logic [15:0] POS_RST    = 16'h0000;

  // sequence field: role and speed
  typedef enum logic [1:0] {
    SEQ_PRI_NORMAL = 2'h0,
    SEQ_SEC_NORMAL = 2'h1,
    SEQ_PRI_FAST   = 2'h2,
    SEQ_SEC_FAST   = 2'h3
  } seq_t;

  // host service requests
  typedef enum logic [1:0] {
    HSR_NONE   = 2'h0,
    HSR_UNUSED = 2'h1,
    HSR_READTB = 2'h2,
    HSR_INIT   = 2'h3
  } hsr_t;

  // channel priority
  typedef enum logic [1:0] {
    PRI_OFF  = 2'h0,
    PRI_LOW  = 2'h1,
    PRI_MED  = 2'h2,
    PRI_HIGH = 2'h3
  } pri_t;

  // register bus request carrier
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

endpackage

// [bench/quad_decoder_asserts.sv]
// port checker for the quadrature position decoder
// assumes it is bound onto the decoder top module
`timescale 1ns/1ns
module quad_decoder_asserts #(
  parameter logic [3:0] FUNC_CODE = 4'h6
) (
  // clock and reset
  input wire logic               CLOCK,
  input wire logic               ARST_N,
  // register port and pins
  input wire quad_pkg::bus_req_t BUS_REQ,
  input wire logic [15:0]        BUS_RDATA,
  input wire logic               PHASE_A,
  input wire logic               PHASE_B,
  input wire logic [3:0]         FUNC_SEL,
  input wire logic               FAST_ACTIVE
);
  import quad_pkg::*;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  // ****
  // read slots
  // ****
  wire logic rd_pos = BUS_REQ.rd && BUS_REQ.addr == OFF_POSITION;
  wire logic rd_tb  = BUS_REQ.rd && BUS_REQ.addr == OFF_TIMEBASE;
  chk_rdata_idle: assert property (!$past(BUS_REQ.rd) |-> BUS_RDATA == 16'h0000)
    else $error("read data outside its slot");
  chk_func_code: assert property (FUNC_SEL == FUNC_CODE)
    else $error("function select differs");
  chk_status_code: assert property ($past(BUS_REQ.rd && BUS_REQ.addr == OFF_STATUS) |-> BUS_RDATA[4:1] == FUNC_CODE)
    else $error("status code wrong");
  chk_unmapped_zero: assert property ($past(BUS_REQ.rd && BUS_REQ.addr > OFF_TIMEBASE) |-> BUS_RDATA == 16'h0000)
    else $error("unmapped read not zero");
  chk_request_reads: assert property ($past(BUS_REQ.rd && BUS_REQ.addr == OFF_CTRL) |-> BUS_RDATA[3:2] == 2'h0)
    else $error("service request readable");
  chk_timebase_step: assert property (rd_tb ##1 rd_tb |=> BUS_RDATA == $past(BUS_RDATA) + 16'h0001)
    else $error("timebase not counting");
  chk_position_hold: assert property ((rd_pos && $stable({PHASE_A, PHASE_B})) ##1 rd_pos
    |=> BUS_RDATA == $past(BUS_RDATA))
    else $error("position moved without edge");
  chk_fast_on_edge: assert property ($rose(FAST_ACTIVE) |-> $past({PHASE_A, PHASE_B}) != $past({PHASE_A, PHASE_B}, 2))
    else $error("speed switch without edge");
endmodule

bind quadrature_position_decoder quad_decoder_asserts #(.FUNC_CODE(FUNC_CODE)) quad_decoder_asserts_inst (
  .CLOCK(CLOCK), .ARST_N(ARST_N), .BUS_REQ(BUS_REQ), .BUS_RDATA(BUS_RDATA),
  .PHASE_A(PHASE_A), .PHASE_B(PHASE_B), .FUNC_SEL(FUNC_SEL), .FAST_ACTIVE(FAST_ACTIVE));

// [bench/quad_encoder_model.sv]
// slotted shaft encoder with two phase outputs, no index output
// assumes the bench commands one slot move per step pulse
`timescale 1ns/1ns
module quad_encoder_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // slot move command
  input wire logic step,
  input wire logic up,
  // phases
  output logic     phase_a,
  output logic     phase_b
);
  logic [1:0] slot_r;
  // one phase changes per slot, so no double jumps reach the decoder
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slot_r <= 2'h0;
    end else if (step) begin
      slot_r <= up ? slot_r + 2'h1 : slot_r - 2'h1;
    end
  end
  // gray order on {b, a} 00,01,11,10 going up, so a leads; no third channel
  assign phase_a = slot_r[1] ^ slot_r[0];
  assign phase_b = slot_r[1];
endmodule

// [bench/quadrature_position_decoder_tb_top.sv]
// self-checking bench for the quadrature position decoder
// assumes the encoder model drives the phases
`timescale 1ns/1ns
module quadrature_position_decoder_tb_top;
  import quad_pkg::*;
  localparam logic [3:0] FC = 4'h9; // arbitrary function code
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  bus_req_t    req = '0;
  logic        stp = 1'b0;
  logic        up = 1'b0;
  logic        pa, pb, fast;
  logic        even_slot;
  logic [3:0]  fsel;
  logic [15:0] rdata, pos_x, d0, d1, t0;
  logic [31:0] rnd = 32'hFD4560D8;
  int          miscompares = 0;
  int          samples_checked = 0;
  quadrature_position_decoder #(.FUNC_CODE(FC)) quadrature_position_decoder_inst (.CLOCK(clock),
    .ARST_N(arst_n), .BUS_REQ(req), .BUS_RDATA(rdata), .PHASE_A(pa), .PHASE_B(pb), .FUNC_SEL(fsel),
    .FAST_ACTIVE(fast));
  quad_encoder_model quad_encoder_model_inst (.clk(clock), .arst_n(arst_n), .step(stp), .up(up),
    .phase_a(pa), .phase_b(pb));
  initial forever #5 clock = ~clock;
  // ****
  // helpers
  // ****
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic logic [15:0] ctl(input logic [1:0] pri, hsr, seq);
    return {SPEED_RST, 2'h0, pri, hsr, seq};
  endfunction
  task automatic check(input string name, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req <= '0;
  endtask
  // two reads with no gap, so both read slots are seen
  task automatic rd2(input logic [3:0] a, output logic [15:0] r0, r1);
    @(posedge clock);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    #1 r0 = rdata;
    @(posedge clock);
    req <= '0;
    #1 r1 = rdata;
  endtask
  task automatic step(input logic dir, input int gap);
    @(posedge clock);
    stp <= 1'b1;
    up <= dir;
    @(posedge clock);
    stp <= 1'b0;
    repeat (gap) @(posedge clock);
    #1 pos_x = dir ? pos_x + 16'h0001 : pos_x - 16'h0001;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard, well beyond the few thousand cycles needed
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    pos_x = POS_RST;
    rd2(OFF_CTRL, d0, d1);
    check("control", d0, {SPEED_RST, 8'h00});
    rd2(OFF_POSITION, d0, d1);
    check("position", d0, POS_RST);
    rd2(OFF_STATUS, d0, d1);
    check("status", d0, {11'h000, FC, 1'b0});
    check("function select", 16'(fsel), 16'(FC));
    rd2(4'hF, d0, d1);
    check("unmapped", d0, 16'h0000);
    rd2(OFF_TIMEBASE, d0, d1);
    check("timebase", d1, d0 + 16'h0001);
    // each code pair; slow edges keep fast mode off
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CTRL, ctl(2'(i), HSR_NONE, 2'(i)));
      rd2(OFF_CTRL, d0, d1);
      check("control", d0, ctl(2'(i), HSR_NONE, 2'(i)));
      step(1'b1, 20);
      if (i == 0) pos_x = pos_x - 16'h0001;
      rd2(OFF_POSITION, d0, d1);
      check("position", d0, pos_x);
    end
    wr(OFF_CTRL, ctl(PRI_HIGH, HSR_NONE, SEQ_PRI_NORMAL));
    repeat (300) begin
      rnd = xs(rnd);
      step(rnd[0], int'(rnd[3:1]));
    end
    rd2(OFF_POSITION, d0, d1);
    check("position", d0, pos_x);
    check("fast normal", 16'(fast), 16'h0000);
    rd2(OFF_STAMP, d0, d1);
    step(1'b1, 4);
    rd2(OFF_STAMP, t0, d1);
    check("stamp hold", d1, t0);
    check("stamp moved", 16'(d0 != t0), 16'h0001);
    // service requests: unused, capture timebase, initialize
    wr(OFF_CTRL, ctl(PRI_HIGH, HSR_UNUSED, SEQ_PRI_NORMAL));
    rd2(OFF_POSITION, d0, d1);
    check("position", d0, pos_x);
    wr(OFF_CTRL, ctl(PRI_HIGH, HSR_READTB, SEQ_PRI_NORMAL));
    rd2(OFF_TBREAD, d0, d1);
    rd2(OFF_TIMEBASE, t0, d1);
    check("capture age", t0 - d0, 16'h0005);
    wr(OFF_CTRL, ctl(PRI_HIGH, HSR_INIT, SEQ_PRI_NORMAL));
    pos_x = 16'h0000;
    step(1'b0, 4);
    rd2(OFF_POSITION, d0, d1);
    check("position wrap", d0, pos_x);
    // close edges engage the speed switch, slow ones release it
    wr(OFF_CTRL, ctl(PRI_HIGH, HSR_NONE, SEQ_PRI_FAST));
    even_slot = (pa == pb);
    repeat (8) step(1'b1, 0);
    check("fast on", 16'(fast), 16'h0001);
    repeat (3) step(1'b1, 20);
    check("fast off", 16'(fast), 16'h0000);
    // moves 3 to 9 count two per A edge only; A edges leave even slots
    rd2(OFF_POSITION, d0, d1);
    check("fast position", d0, even_slot ? 16'h000B : 16'h0009);
    report_and_stop();
  end
endmodule
